//--- verilog/csr_pkg.sv
// Constants and carrier types for the rail sleep and mode control bank.
// Assumes an internal byte-wide register port from the serial host interface.
// Operation
// [RL1] Rail3 sleep code held in bits 7:1
// [RL2] Rail3 enable selects sleep code when pin low
// [RL3] Each rail follows one factory-chosen sleep pin
// [RL4] Rail4 enable 00 normal, 11 sleep when low
// [RL5] Rail5 enable 00 normal, 11 sleep when low
// [RL6] Host never writes reserved enable codes 01/10
// [RL7] Host writes 11 into bits 3:2
// [RL8] Rail4 bit 1 selects auto or forced PWM
// [RL9] Rail5 bit 1 selects auto or forced PWM
// [RL10] Rail4 disable bit 0 forces rail off
// [RL11] Rail5 disable bit 0 forces rail off
// [RL12] Bits 7:6 read-only zero, rest writable
// [RL13] Rail3 normal code at 23h bits 7:1
// [RL14] Reserved enable codes act as disabled
package csr_pkg;
	localparam logic [7:0] CSR_OFF_R3_NORM = 8'h23;
	localparam logic [7:0] CSR_OFF_R3_SLP = 8'h24;
	localparam logic [7:0] CSR_OFF_R4_CTRL = 8'h25;
	localparam logic [7:0] CSR_OFF_R5_CTRL = 8'h26;
	localparam int CSR_CODE_LSB = 1;
	localparam int CSR_CODE_MSB = 7;
	localparam int CSR_EN_BIT = 0;
	localparam int CSR_SLP_LO = 4;
	localparam int CSR_SLP_HI = 5;
	localparam int CSR_MODE_BIT = 1;
	localparam int CSR_DIS_BIT = 0;
	localparam logic [7:0] CSR_CTRL_WMASK = 8'h3F;
	localparam logic [1:0] CSR_SLP_ON = 2'h3;
	localparam logic [1:0] CSR_SLP_OFF = 2'h0;
	localparam logic [7:0] CSR_RST_NORM = 8'h00;
	localparam logic [7:0] CSR_RST_SLP = 8'h00;
	localparam logic [7:0] CSR_RST_CTRL = 8'h0F;

	typedef struct packed {
		logic [6:0] voltage_code;
		logic forced_pwm;
		logic rail_on;
	} csr_rail_t;
endpackage

//--- verilog/csr_rail_sel.sv
// Per-rail voltage code selection between normal and sleep codes.
// Assumes sleep pins are synchronous levels, active low.
module csr_rail_sel
	import csr_pkg::*;
(
	input wire logic [6:0] i_normal_code,
	input wire logic [6:0] i_sleep_code,
	input wire logic [1:0] i_sleep_enable,
	input wire logic i_pin_sel,
	input wire logic i_sleep_pin_a,
	input wire logic i_sleep_pin_b,
	output logic [6:0] o_code
);
	logic pin_low;
	logic use_sleep;

	always_comb begin
		pin_low = i_pin_sel ? !i_sleep_pin_b : !i_sleep_pin_a; // RL3
		// Reserved codes fall back to the normal code
		use_sleep = (i_sleep_enable == CSR_SLP_ON) && pin_low; // RL14
		o_code = use_sleep ? i_sleep_code : i_normal_code;
	end
endmodule

//--- verilog/csr_sleep_ctrl.sv
// Register bank and rail outputs for rails three to five.
// Assumes a byte register port from the host interface and factory pin straps.
module csr_sleep_ctrl
	import csr_pkg::*;
#(
	parameter int NUM_PINS = 6
)
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [NUM_PINS-1:0] i_control_input_pins,
	input wire logic i_sleep_pin_a_n,
	input wire logic i_sleep_pin_b_n,
	input wire logic [2:0] i_pin_sel,
	input wire logic [2:0] i_pin_enable,
	input wire logic [6:0] i_rail4_normal_voltage_code,
	input wire logic [6:0] i_rail4_sleep_voltage_code,
	input wire logic [6:0] i_rail5_normal_voltage_code,
	input wire logic [6:0] i_rail5_sleep_voltage_code,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output csr_rail_t o_rail3,
	output csr_rail_t o_rail4,
	output csr_rail_t o_rail5
);
	if (NUM_PINS < 1) begin : g_chk
		$error("NUM_PINS must be at least 1");
	end

	logic [7:0] norm_r;
	logic [7:0] slp_r;
	logic [7:0] ctrl4_r;
	logic [7:0] ctrl5_r;
	logic [7:0] rdata_nxt;
	logic [6:0] code3;
	logic [6:0] code4;
	logic [6:0] code5;
	logic [1:0] slp3;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// Writable registers
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			norm_r <= CSR_RST_NORM;
			slp_r <= CSR_RST_SLP;
			ctrl4_r <= CSR_RST_CTRL;
			ctrl5_r <= CSR_RST_CTRL;
		end else if (i_wr) begin
			if (hit(i_addr, CSR_OFF_R3_NORM))
				norm_r <= {i_wdata[CSR_CODE_MSB:CSR_CODE_LSB], 1'b0}; // RL13
			if (hit(i_addr, CSR_OFF_R3_SLP))
				slp_r <= i_wdata; // RL1
			// Bits 7:6 cannot be written; bits 3:2 kept as given
			if (hit(i_addr, CSR_OFF_R4_CTRL))
				ctrl4_r <= i_wdata & CSR_CTRL_WMASK; // RL12
			if (hit(i_addr, CSR_OFF_R5_CTRL))
				ctrl5_r <= i_wdata & CSR_CTRL_WMASK; // RL12
		end
	end

	always_comb begin
		case (i_addr)
			CSR_OFF_R3_NORM: rdata_nxt = norm_r;
			CSR_OFF_R3_SLP: rdata_nxt = slp_r;
			CSR_OFF_R4_CTRL: rdata_nxt = ctrl4_r;
			CSR_OFF_R5_CTRL: rdata_nxt = ctrl5_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	// Read answer one cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd;
			o_rdata <= i_rd ? rdata_nxt : 8'h00;
		end
	end

	// Single enable bit widened to the two-bit code
	assign slp3 = slp_r[CSR_EN_BIT] ? CSR_SLP_ON : CSR_SLP_OFF; // RL2

	csr_rail_sel u_sel3 (
		.i_normal_code(norm_r[CSR_CODE_MSB:CSR_CODE_LSB]),
		.i_sleep_code(slp_r[CSR_CODE_MSB:CSR_CODE_LSB]),
		.i_sleep_enable(slp3),
		.i_pin_sel(i_pin_sel[0]),
		.i_sleep_pin_a(i_sleep_pin_a_n),
		.i_sleep_pin_b(i_sleep_pin_b_n),
		.o_code(code3)
	);
	csr_rail_sel u_sel4 (
		.i_normal_code(i_rail4_normal_voltage_code),
		.i_sleep_code(i_rail4_sleep_voltage_code),
		.i_sleep_enable(ctrl4_r[CSR_SLP_HI:CSR_SLP_LO]), // RL4
		.i_pin_sel(i_pin_sel[1]),
		.i_sleep_pin_a(i_sleep_pin_a_n),
		.i_sleep_pin_b(i_sleep_pin_b_n),
		.o_code(code4)
	);
	csr_rail_sel u_sel5 (
		.i_normal_code(i_rail5_normal_voltage_code),
		.i_sleep_code(i_rail5_sleep_voltage_code),
		.i_sleep_enable(ctrl5_r[CSR_SLP_HI:CSR_SLP_LO]), // RL5
		.i_pin_sel(i_pin_sel[2]),
		.i_sleep_pin_a(i_sleep_pin_a_n),
		.i_sleep_pin_b(i_sleep_pin_b_n),
		.o_code(code5)
	);

	// Registered rail outputs; disable bit overrides the rail4 and rail5 pin enables
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_rail3 <= '0;
			o_rail4 <= '0;
			o_rail5 <= '0;
		end else begin
			o_rail3 <= '{voltage_code: code3, forced_pwm: 1'b0, rail_on: i_pin_enable[0]};
			o_rail4 <= '{voltage_code: code4, forced_pwm: ctrl4_r[CSR_MODE_BIT], // RL8
				rail_on: i_pin_enable[1] && ctrl4_r[CSR_DIS_BIT]}; // RL10
			o_rail5 <= '{voltage_code: code5, forced_pwm: ctrl5_r[CSR_MODE_BIT], // RL9
				rail_on: i_pin_enable[2] && ctrl5_r[CSR_DIS_BIT]}; // RL11
		end
	end

	rail4_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!ctrl4_r[CSR_DIS_BIT] |=> !o_rail4.rail_on) else $error("rail4 on while disabled"); // RL10
	rail5_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!ctrl5_r[CSR_DIS_BIT] |=> !o_rail5.rail_on) else $error("rail5 on while disabled"); // RL11
	r4_mode_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> o_rail4.forced_pwm == $past(ctrl4_r[CSR_MODE_BIT])) else $error("rail4 mode"); // RL8
	r5_mode_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> o_rail5.forced_pwm == $past(ctrl5_r[CSR_MODE_BIT])) else $error("rail5 mode"); // RL9
	r3_sleep_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(slp_r[CSR_EN_BIT] && !i_pin_sel[0] && !i_sleep_pin_a_n)
		|=> o_rail3.voltage_code == $past(slp_r[CSR_CODE_MSB:CSR_CODE_LSB])) else $error("rail3 sleep"); // RL2
	r3_norm_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!slp_r[CSR_EN_BIT] |=> o_rail3.voltage_code == $past(norm_r[CSR_CODE_MSB:CSR_CODE_LSB]))
		else $error("rail3 normal"); // RL13
	r4_resv_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(ctrl4_r[CSR_SLP_HI:CSR_SLP_LO] != CSR_SLP_ON)
		|=> o_rail4.voltage_code == $past(i_rail4_normal_voltage_code)) else $error("rail4 code"); // RL4
	r5_resv_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(ctrl5_r[CSR_SLP_HI:CSR_SLP_LO] != CSR_SLP_ON)
		|=> o_rail5.voltage_code == $past(i_rail5_normal_voltage_code)) else $error("rail5 code"); // RL14
	ro_bits_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(ctrl4_r[7:6] == 2'h0) && (ctrl5_r[7:6] == 2'h0)) else $error("read-only bits set"); // RL12
	r5_sleep_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(ctrl5_r[CSR_SLP_HI:CSR_SLP_LO] == CSR_SLP_ON && i_pin_sel[2] && !i_sleep_pin_b_n)
		|=> o_rail5.voltage_code == $past(i_rail5_sleep_voltage_code)) else $error("rail5 sleep"); // RL5
	r4_sleep_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(ctrl4_r[CSR_SLP_HI:CSR_SLP_LO] == CSR_SLP_ON && !i_pin_sel[1] && !i_sleep_pin_a_n)
		|=> o_rail4.voltage_code == $past(i_rail4_sleep_voltage_code)) else $error("rail4 sleep"); // RL4
	// Pin b strap must ignore pin a entirely
	r3_pinb_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(slp_r[CSR_EN_BIT] && i_pin_sel[0] && i_sleep_pin_b_n)
		|=> o_rail3.voltage_code == $past(norm_r[CSR_CODE_MSB:CSR_CODE_LSB])) else $error("rail3 pin"); // RL3
	r3_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_rd && i_addr == CSR_OFF_R3_SLP) |=> o_rvalid && o_rdata == $past(slp_r)) else $error("read"); // RL1
endmodule

//--- tb/csr_sleep_ctrl_test.sv
// Random register and pin traffic against a bench model of the bank.
// Assumes one-cycle read answer and rail outputs lagging writes by two edges.
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, s); end end
module csr_sleep_ctrl_test
	import csr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, pa_n = 1, pb_n = 1, o_rvalid;
	logic [7:0] i_addr = 0, i_wdata = 0, o_rdata, a, d;
	logic [5:0] ctl = 0;
	logic [2:0] sel = 0, pen = 0;
	logic [6:0] n4 = 0, s4 = 0, n5 = 0, s5 = 0;
	logic [7:0] regs [4];
	csr_rail_t o_rail3, o_rail4, o_rail5;
	int n_errors = 0, checks_done = 0;

	csr_sleep_ctrl #(.NUM_PINS(6)) DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_wr(i_wr), .i_rd(i_rd),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_control_input_pins(ctl), .i_sleep_pin_a_n(pa_n),
		.i_sleep_pin_b_n(pb_n), .i_pin_sel(sel), .i_pin_enable(pen), .i_rail4_normal_voltage_code(n4),
		.i_rail4_sleep_voltage_code(s4), .i_rail5_normal_voltage_code(n5), .i_rail5_sleep_voltage_code(s5),
		.o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_rail3(o_rail3), .o_rail4(o_rail4), .o_rail5(o_rail5));

	initial forever #12.5 i_clk = ~i_clk;

	// Reserved enable codes fall through to the normal code
	function automatic csr_rail_t exp_rail(input logic [1:0] slp, input logic [6:0] nc, sc,
		input logic ps, mode, on);
		csr_rail_t r;
		logic low;
		low = ps ? !pb_n : !pa_n;
		r.voltage_code = (slp == 2'h3 && low) ? sc : nc;
		r.forced_pwm = mode;
		r.rail_on = on;
		return r;
	endfunction

	task automatic wr(input logic [7:0] ad, d);
		i_wr = 1;
		i_addr = ad;
		i_wdata = d;
		@(posedge i_clk);
		#1;
		i_wr = 0;
		if (ad == 8'h23) regs[0] = d & 8'hFE;
		if (ad == 8'h24) regs[1] = d;
		if (ad == 8'h25 || ad == 8'h26) regs[ad - 8'h23] = d & 8'h3F;
	endtask

	// Unmapped offsets answer zero but still raise the valid pulse
	task automatic rd(input logic [7:0] ad);
		logic [7:0] e;
		e = (ad >= 8'h23 && ad <= 8'h26) ? regs[ad - 8'h23] : 8'h00;
		i_rd = 1;
		i_addr = ad;
		@(posedge i_clk);
		#1;
		i_rd = 0;
		`CHK("rvalid", 1'b1, o_rvalid)
		`CHK("rdata", e, o_rdata)
	endtask

	task automatic results();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#100000;
		n_errors++;
		results();
	end

	initial begin
		void'($urandom(90));
		regs = '{8'h00, 8'h00, 8'h0F, 8'h0F};
		repeat (8) @(posedge i_clk);
		#1;
		`CHK("reset rails", 27'h0, {o_rail3, o_rail4, o_rail5})
		i_nrst = 1;
		for (int k = 0; k < 5; k++) rd(8'h22 + 8'(k));
		repeat (300) begin
			{pa_n, pb_n, sel, pen, ctl} = 14'($urandom);
			{n4, s4, n5, s5} = 28'($urandom);
			a = 8'h20 + 8'($urandom % 8);
			d = 8'($urandom);
			// Host keeps legal enable codes and writes 11 into the reserved pair
			if (a == 8'h25 || a == 8'h26) d = {d[7:6], {2{d[4]}}, 2'b11, d[1:0]};
			wr(a, d);
			rd(a);
			`CHK("rail3", exp_rail({2{regs[1][0]}}, regs[0][7:1], regs[1][7:1], sel[0], 1'b0, pen[0]), o_rail3)
			`CHK("rail4", exp_rail(regs[2][5:4], n4, s4, sel[1], regs[2][1], regs[2][0] & pen[1]), o_rail4)
			`CHK("rail5", exp_rail(regs[3][5:4], n5, s5, sel[2], regs[3][1], regs[3][0] & pen[2]), o_rail5)
		end
		results();
	end
endmodule
